// File: laser_ctrl_regs.svh
`ifndef LASER_CTRL_REGS_SVH
`define LASER_CTRL_REGS_SVH

// register byte offsets
`define OFS_CTRL 8'h00
`define OFS_SETP 8'h04
`define OFS_LIMIT 8'h08
`define OFS_ERR 8'h0C
`define OFS_CMD 8'h10
`define OFS_STAT 8'h14

// control register bits
`define CTL_SW_EN 0
`define CTL_EXT_SP 1
`define CTL_EN_EXT 2
`define CTL_DEF_PWRON 3
`define CTL_ZERO_SCALE 7

// error, command and status bits
`define ERR_OVERTEMP 0
`define ERR_FAULT 1
`define ERR_SELFTEST 2
`define CMD_LOAD 0
`define CMD_SAVE 1
`define ST_TGT_LSB 8
`define ST_OUT_EN 16
`define ST_DRV_OK 17
`define ST_POST_LSB 18
`define ST_EXT_ACT 20
`define ST_BLOCKED 21
`define ST_PANEL_EN 22

// reset values and limits, currents in 0.1 A steps
`define RST_CTRL 8'h06
`define RST_SETP 8'h0A
`define RST_LIMIT 8'hC8
`define CUR_MIN 8'h0A
`define TEMP_LIMIT_C 8'h50

// timing
`define CLK_NS 64'd4
`define POST_NORMAL_NS 64'd5000000000
`define POST_TIMEOUT_NS 64'd15000000000
`define RAMP_STEP_NS 64'd4000

`endif

// File: laser_ctrl_pkg.sv
package laser_ctrl_pkg;

    // stored operating settings
    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] setp;
        logic [7:0] limit;
    } settings_t;

    typedef enum logic [1:0] {
        POST_RUN = 2'b00,
        POST_LATE = 2'b01,
        POST_PASS = 2'b10,
        POST_FAIL = 2'b11
    } post_t;

    typedef enum logic [2:0] {
        REG_CTRL = 3'b000,
        REG_SETP = 3'b001,
        REG_LIMIT = 3'b010,
        REG_ERR = 3'b011,
        REG_CMD = 3'b100,
        REG_STAT = 3'b101,
        REG_NONE = 3'b110
    } reg_t;

    typedef struct packed {
        logic s1;
        logic s2;
    } sync_state_t;

    typedef struct packed {
        settings_t [1:0] slot;
    } nv_state_t;

    typedef struct packed {
        logic boot;
        post_t post;
        logic [31:0] cnt;
        settings_t cfg;
        logic ext_act;
        logic [2:0] err;
        logic blocked;
        logic seen_low;
        logic [9:0] rdiv;
        logic [7:0] ramp;
        logic out_en;
        logic drv_ok;
        logic panel_en;
        logic pend;
        logic [7:0] paddr;
        logic pwrite;
        logic hready;
        logic hresp;
        logic [31:0] hrdata;
    } ctl_state_t;

endpackage : laser_ctrl_pkg

// File: enable_sync.sv
`timescale 1ns/1ps

module enable_sync (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // pin and synchronised level
    input wire logic pin,
    output logic level
);

    laser_ctrl_pkg::sync_state_t s;
    laser_ctrl_pkg::sync_state_t n;

    // two stages, first read only by second
    always_comb begin
        n = s;
        n.s1 = pin;
        n.s2 = s.s1;
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign level = s.s2;

endmodule : enable_sync

// File: settings_store.sv
`timescale 1ns/1ps
`include "laser_ctrl_regs.svh"

module settings_store (
    // clock and wipe
    input wire logic mclk,
    input wire logic erase,
    // write side
    input wire logic save,
    input wire logic mirror,
    input wire laser_ctrl_pkg::settings_t cfg,
    // read side
    output laser_ctrl_pkg::settings_t def_cfg,
    output laser_ctrl_pkg::settings_t live_cfg
);

    laser_ctrl_pkg::nv_state_t s;
    laser_ctrl_pkg::nv_state_t n;
    laser_ctrl_pkg::settings_t fresh;

    assign fresh = '{ctrl: `RST_CTRL, setp: `RST_SETP, limit: `RST_LIMIT};

    // slot 0 saved defaults, slot 1 live mirror; survives rst
    always_comb begin
        n = s;
        if (erase) begin
            n.slot[0] = fresh;
            n.slot[1] = fresh;
        end else begin
            if (save) begin
                n.slot[0] = cfg;
            end
            if (mirror) begin
                n.slot[1] = cfg;
            end
        end
    end

    always_ff @(posedge mclk) begin
        s <= n;
    end

    assign def_cfg = s.slot[0];
    assign live_cfg = s.slot[1];

endmodule : settings_store

// File: laser_driver_enable_setpoint_ctrl.sv
// The AHB-Lite slave port and the address map were decided locally.
`timescale 1ns/1ps
`include "laser_ctrl_regs.svh"

module laser_driver_enable_setpoint_ctrl #(
    parameter logic [31:0] POST_NORMAL_CYC = 32'(`POST_NORMAL_NS / `CLK_NS),
    parameter logic [31:0] POST_TIMEOUT_CYC = 32'(`POST_TIMEOUT_NS / `CLK_NS)
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // connector pin
    input wire logic enable_pin,
    // same-clock monitors
    input wire logic [9:0] adc_code,
    input wire logic [7:0] temp_c,
    input wire logic fault_in,
    input wire logic st_ok,
    input wire logic host_link,
    input wire logic nv_erase,
    // driver controls
    output logic out_en,
    output logic drv_ok,
    output logic [7:0] i_set,
    output logic panel_en
);

    localparam logic [9:0] RAMP_CYC = 10'((`RAMP_STEP_NS + `CLK_NS - 64'd1) / `CLK_NS);

    laser_ctrl_pkg::ctl_state_t s;
    laser_ctrl_pkg::ctl_state_t n;
    laser_ctrl_pkg::settings_t def_cfg;
    laser_ctrl_pkg::settings_t live_cfg;
    laser_ctrl_pkg::reg_t sel;
    logic pin_s;
    logic en_src;
    logic low_cut;
    logic tick;
    logic wr;
    logic cmd_load;
    logic cmd_save;
    logic mirror;
    logic [7:0] lo;
    logic [7:0] span;
    logic [17:0] prod;
    logic [7:0] ext_i;
    logic [7:0] raw;
    logic [7:0] target;
    logic [7:0] ctl_rd;
    logic [31:0] rd;

    // byte offset to register
    function automatic laser_ctrl_pkg::reg_t reg_idx(input logic [7:0] a);
        unique case (a)
            `OFS_CTRL: reg_idx = laser_ctrl_pkg::REG_CTRL;
            `OFS_SETP: reg_idx = laser_ctrl_pkg::REG_SETP;
            `OFS_LIMIT: reg_idx = laser_ctrl_pkg::REG_LIMIT;
            `OFS_ERR: reg_idx = laser_ctrl_pkg::REG_ERR;
            `OFS_CMD: reg_idx = laser_ctrl_pkg::REG_CMD;
            `OFS_STAT: reg_idx = laser_ctrl_pkg::REG_STAT;
            default: reg_idx = laser_ctrl_pkg::REG_NONE;
        endcase
    endfunction : reg_idx

    enable_sync u_sync (
        .mclk(mclk),
        .rst(rst),
        .pin(enable_pin),
        .level(pin_s)
    );

    settings_store u_store (
        .mclk(mclk),
        .erase(nv_erase),
        .save(cmd_save),
        .mirror(mirror),
        .cfg(s.cfg),
        .def_cfg(def_cfg),
        .live_cfg(live_cfg)
    );

    // enable source, pin unused in software mode
    assign en_src = s.cfg.ctrl[`CTL_EN_EXT] ? pin_s : s.cfg.ctrl[`CTL_SW_EN];

    // external span bottom and top
    assign lo = s.cfg.ctrl[`CTL_ZERO_SCALE] ? 8'h00 : `CUR_MIN;
    assign span = (s.cfg.limit > lo) ? s.cfg.limit - lo : 8'h00;
    assign prod = {8'h00, adc_code} * {10'h000, span};
    assign ext_i = lo + prod[17:10];
    assign raw = s.ext_act ? ext_i : s.cfg.setp;
    assign target = (raw > s.cfg.limit) ? s.cfg.limit : raw;
    assign low_cut = s.ext_act && s.cfg.ctrl[`CTL_ZERO_SCALE] && (ext_i < `CUR_MIN);

    // bus data phase decode
    assign sel = reg_idx(s.paddr);
    assign wr = s.pend && s.pwrite;
    assign cmd_load = wr && (sel == laser_ctrl_pkg::REG_CMD) && hwdata[`CMD_LOAD];
    assign cmd_save = wr && (sel == laser_ctrl_pkg::REG_CMD) && hwdata[`CMD_SAVE];
    assign mirror = !s.boot && (s.cfg != live_cfg);
    assign tick = (s.rdiv == RAMP_CYC - 10'h001);

    // read mux
    always_comb begin
        ctl_rd = s.cfg.ctrl;
        ctl_rd[`CTL_SW_EN] = en_src;
        rd = 32'h0000_0000;
        unique case (sel)
            laser_ctrl_pkg::REG_CTRL: rd[7:0] = ctl_rd;
            laser_ctrl_pkg::REG_SETP: rd[7:0] = s.cfg.setp;
            laser_ctrl_pkg::REG_LIMIT: rd[7:0] = s.cfg.limit;
            laser_ctrl_pkg::REG_ERR: rd[2:0] = s.err;
            laser_ctrl_pkg::REG_STAT: begin
                rd[7:0] = s.ramp;
                rd[`ST_TGT_LSB +: 8] = target;
                rd[`ST_OUT_EN] = s.out_en;
                rd[`ST_DRV_OK] = s.drv_ok;
                rd[`ST_POST_LSB +: 2] = s.post;
                rd[`ST_EXT_ACT] = s.ext_act;
                rd[`ST_BLOCKED] = s.blocked;
                rd[`ST_PANEL_EN] = s.panel_en;
            end
            default: rd = 32'h0000_0000;
        endcase
    end

    // next state
    always_comb begin
        n = s;
        n.hresp = 1'b0;
        // bus: one wait cycle, then data
        if (s.pend) begin
            n.pend = 1'b0;
            n.hready = 1'b1;
            n.hrdata = s.pwrite ? 32'h0000_0000 : rd;
            if (s.pwrite) begin
                unique case (sel)
                    laser_ctrl_pkg::REG_CTRL: n.cfg.ctrl = hwdata[7:0];
                    laser_ctrl_pkg::REG_SETP: n.cfg.setp = hwdata[7:0];
                    laser_ctrl_pkg::REG_LIMIT: n.cfg.limit = hwdata[7:0];
                    default: n.cfg = s.cfg;
                endcase
            end
        end else if (hsel && htrans[1] && hready) begin
            n.pend = 1'b1;
            n.hready = 1'b0;
            n.paddr = haddr[7:0];
            n.pwrite = hwrite;
        end
        // first cycle after reset: last or default set
        if (s.boot) begin
            n.boot = 1'b0;
            n.cfg = live_cfg.ctrl[`CTL_DEF_PWRON] ? def_cfg : live_cfg;
            n.cfg.ctrl[`CTL_SW_EN] = 1'b0;
        end
        // source select follows only while off
        if (!s.out_en) begin
            n.ext_act = s.cfg.ctrl[`CTL_EXT_SP];
        end
        // re-arm on sampled low then high
        if (s.blocked) begin
            if (!en_src) begin
                n.seen_low = 1'b1;
            end else if (s.seen_low) begin
                n.blocked = 1'b0;
                n.seen_low = 1'b0;
                n.err[`ERR_OVERTEMP] = 1'b0;
                n.err[`ERR_FAULT] = 1'b0;
            end
        end
        // restore saved set, output stays off; beats a same-cycle re-arm
        if (cmd_load) begin
            n.cfg = def_cfg;
            n.cfg.ctrl[`CTL_SW_EN] = 1'b0;
            n.blocked = 1'b1;
            n.seen_low = 1'b0;
        end
        // error sets after clear, so set wins
        if (temp_c > `TEMP_LIMIT_C) begin
            n.err[`ERR_OVERTEMP] = 1'b1;
            n.blocked = 1'b1;
            n.seen_low = 1'b0;
        end
        if (fault_in) begin
            n.err[`ERR_FAULT] = 1'b1;
            n.blocked = 1'b1;
            n.seen_low = 1'b0;
        end
        // power-on self test
        unique case (s.post)
            laser_ctrl_pkg::POST_RUN: begin
                n.cnt = s.cnt + 32'h0000_0001;
                if (st_ok) begin
                    n.post = laser_ctrl_pkg::POST_PASS;
                end else if (s.cnt == POST_NORMAL_CYC) begin
                    n.post = laser_ctrl_pkg::POST_LATE;
                end
            end
            laser_ctrl_pkg::POST_LATE: begin
                n.cnt = s.cnt + 32'h0000_0001;
                if (st_ok) begin
                    n.post = laser_ctrl_pkg::POST_PASS;
                end else if (s.cnt == POST_TIMEOUT_CYC) begin
                    n.post = laser_ctrl_pkg::POST_FAIL;
                    n.cnt = s.cnt;
                    n.err[`ERR_SELFTEST] = 1'b1;
                end
            end
            laser_ctrl_pkg::POST_PASS: n.cnt = s.cnt;
            laser_ctrl_pkg::POST_FAIL: n.cnt = s.cnt;
        endcase
        // output stage gating
        n.out_en = (s.post == laser_ctrl_pkg::POST_PASS) && en_src && !s.blocked
            && (s.err == 3'b000) && !low_cut;
        n.drv_ok = (s.post == laser_ctrl_pkg::POST_PASS) && (s.err == 3'b000);
        // soft-start ramp
        n.rdiv = tick ? 10'h000 : s.rdiv + 10'h001;
        if (!n.out_en) begin
            n.ramp = 8'h00;
        end else if (s.ramp > target) begin
            n.ramp = target;
        end else if (tick && (s.ramp < target)) begin
            n.ramp = s.ramp + 8'h01;
        end
        // host takes over, settings untouched
        n.panel_en = !host_link;
    end

    // state register
    always_ff @(posedge mclk) begin
        if (rst) begin
            s <= '0;
            s.boot <= 1'b1;
            s.cfg <= '{ctrl: `RST_CTRL, setp: `RST_SETP, limit: `RST_LIMIT};
            s.blocked <= 1'b1;
            s.hready <= 1'b1;
            s.panel_en <= 1'b1;
        end else begin
            s <= n;
        end
    end

    // outputs
    assign hrdata = s.hrdata;
    assign hreadyout = s.hready;
    assign hresp = s.hresp;
    assign out_en = s.out_en;
    assign drv_ok = s.drv_ok;
    assign i_set = s.ramp;
    assign panel_en = s.panel_en;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    property p_clamp;
        $stable(s.cfg.limit) |-> (s.ramp <= s.cfg.limit);
    endproperty
    a_clamp: assert property (p_clamp) else $error("setpoint above limit");

    property p_srcsel;
        $past(s.out_en) && s.out_en |-> $stable(s.ext_act);
    endproperty
    a_srcsel: assert property (p_srcsel) else $error("source changed while on");

    property p_lowcut;
        low_cut |=> !s.out_en;
    endproperty
    a_lowcut: assert property (p_lowcut) else $error("low external not cut");

    property p_otemp;
        (temp_c > `TEMP_LIMIT_C) |=> (s.err[`ERR_OVERTEMP] && s.blocked) ##1 !s.out_en;
    endproperty
    a_otemp: assert property (p_otemp) else $error("overtemp not latched");

    property p_rearm;
        $rose(s.out_en) |-> $past(s.blocked, 2) == 1'b0 || $past(s.seen_low, 2);
    endproperty
    a_rearm: assert property (p_rearm) else $error("enabled without toggle");

    property p_post;
        (s.post != laser_ctrl_pkg::POST_PASS) |=> !s.drv_ok && !s.out_en;
    endproperty
    a_post: assert property (p_post) else $error("output before self test");

    property p_posttime;
        s.cnt <= POST_TIMEOUT_CYC;
    endproperty
    a_posttime: assert property (p_posttime) else $error("self test overran");

    property p_err;
        (s.err != 3'b000) |=> !s.drv_ok && !s.out_en;
    endproperty
    a_err: assert property (p_err) else $error("error left output on");

    property p_panel;
        host_link |=> !s.panel_en;
    endproperty
    a_panel: assert property (p_panel) else $error("panel not disabled");

    property p_swmode;
        !s.cfg.ctrl[`CTL_EN_EXT] && !s.cfg.ctrl[`CTL_SW_EN] |=> !s.out_en;
    endproperty
    a_swmode: assert property (p_swmode) else $error("pin used in software mode");

    property p_ramp;
        $past(s.out_en) && (s.ramp > $past(s.ramp)) |-> s.ramp == $past(s.ramp) + 8'h01;
    endproperty
    a_ramp: assert property (p_ramp) else $error("setpoint stepped");

endmodule : laser_driver_enable_setpoint_ctrl

// File: enable_panel.sv
`timescale 1ns/1ps

module enable_panel (
    // clock
    input wire logic mclk,
    // operator commands
    input wire logic want_en,
    input wire logic [9:0] want_code,
    // connector outputs
    output logic enable_pin = 1'b0,
    output logic [9:0] adc_code = 10'h000
);
    // levels move just after an edge and stand at least one whole cycle
    always @(posedge mclk) begin
        enable_pin <= want_en;
        adc_code <= want_code;
    end
endmodule : enable_panel

// File: laser_driver_enable_setpoint_ctrl_test.sv
`timescale 1ns/1ps
`include "laser_ctrl_regs.svh"

module laser_driver_enable_setpoint_ctrl_test;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic want_en = 1'b0;
    logic [9:0] want_code = 10'h200;
    logic enable_pin;
    logic [9:0] adc_code;
    logic [7:0] temp_c = 8'h19;
    logic fault_in = 1'b0;
    logic st_ok = 1'b0;
    logic host_link = 1'b0;
    logic nv_erase = 1'b1;
    logic out_en;
    logic drv_ok;
    logic [7:0] i_set;
    logic panel_en;
    logic out_en_w;
    logic drv_ok_w;
    logic [7:0] i_set_w;
    logic panel_en_w;
    logic ready_s;
    logic [31:0] rdata_s;
    logic [31:0] rd;
    int num_errors = 0;
    int n_tests = 0;
    int cyc = 0;

    // 250 MHz clock
    always #2 mclk = ~mclk;

    // outputs taken mid-cycle, so each edge sees what stood before it
    always @(negedge mclk) begin
        out_en <= out_en_w;
        drv_ok <= drv_ok_w;
        i_set <= i_set_w;
        panel_en <= panel_en_w;
        ready_s <= hreadyout;
        rdata_s <= hrdata;
    end

    // operator side of the connector
    enable_panel panel (.mclk(mclk), .want_en(want_en), .want_code(want_code),
        .enable_pin(enable_pin), .adc_code(adc_code));

    // short self test counts keep the run brief
    laser_driver_enable_setpoint_ctrl #(.POST_NORMAL_CYC(32'd20), .POST_TIMEOUT_CYC(32'd50)) dut (
        .mclk(mclk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .enable_pin(enable_pin), .adc_code(adc_code), .temp_c(temp_c),
        .fault_in(fault_in), .st_ok(st_ok), .host_link(host_link), .nv_erase(nv_erase),
        .out_en(out_en_w), .drv_ok(drv_ok_w), .i_set(i_set_w), .panel_en(panel_en_w));

    task automatic tally_and_finish;
        $display("errors %0d, checks %0d", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : tally_and_finish

    // hang guard
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            num_errors++;
            tally_and_finish();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic chk1(input logic seen, input logic exp);
        check({31'h0, seen}, {31'h0, exp});
    endtask : chk1

    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask : tick

    // one single ahb-lite word transfer, read data lands in rd
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= wr;
        hsize <= 3'h2;
        do @(posedge mclk); while (ready_s !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= wd;
        do @(posedge mclk); while (ready_s !== 1'b1);
        rd = rdata_s;
        chk1(hresp, 1'b0);
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask : wr

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        check(rd, exp);
    endtask : rdchk

    // read status and compare the target field
    task automatic tgt(input logic [31:0] exp);
        bus(1'b0, `OFS_STAT, 32'h0);
        check({24'h0, rd[15:8]}, exp);
    endtask : tgt

    // bounded wait for the output enable to reach a level
    task automatic wait_en(input logic v);
        int n;
        n = 0;
        while (out_en !== v && n < 40) begin
            @(posedge mclk);
            n++;
        end
        chk1(out_en, v);
    endtask : wait_en

    // expected external target: lo plus scaled code, ten-bit shift
    function automatic logic [31:0] scale(input int code, input int lo, input int lim);
        return 32'(lo + ((code * (lim - lo)) >> 10));
    endfunction : scale

    // main sequence
    initial begin
        tick(12);
        rst <= 1'b0;
        nv_erase <= 1'b0;
        tick(2);
        chk1(drv_ok, 1'b0);
        rdchk(`OFS_CTRL, {24'h0, `RST_CTRL});
        rdchk(`OFS_SETP, {24'h0, `RST_SETP});
        rdchk(`OFS_LIMIT, {24'h0, `RST_LIMIT});
        wr(8'h18, 32'h5A);
        rdchk(8'h18, 32'h0);
        want_en <= 1'b1;
        tick(8);
        chk1(out_en, 1'b0);
        st_ok <= 1'b1;
        tick(3);
        chk1(drv_ok, 1'b1);
        want_en <= 1'b0;
        tick(5);
        want_en <= 1'b1;
        wait_en(1'b1);
        rdchk(`OFS_CTRL, 32'h07);
        tgt(scale(512, 10, 200));
        tick(1500);
        chk1(i_set != 8'h00 && i_set < 8'h69, 1'b1);
        // zero-based scaling and the low-current cut-off
        wr(`OFS_CTRL, 32'h86);
        tick(3);
        tgt(scale(512, 0, 200));
        want_code <= 10'h014;
        wait_en(1'b0);
        want_code <= 10'h200;
        wait_en(1'b1);
        // source change waits for the output to be off
        wr(`OFS_CTRL, 32'h84);
        bus(1'b0, `OFS_STAT, 32'h0);
        chk1(rd[20], 1'b1);
        want_en <= 1'b0;
        wait_en(1'b0);
        tick(3);
        bus(1'b0, `OFS_STAT, 32'h0);
        chk1(rd[20], 1'b0);
        wr(`OFS_SETP, 32'hFF);
        tgt(32'hC8);
        wr(`OFS_LIMIT, 32'h32);
        tgt(32'h32);
        // over-temperature latch and its clearing toggle
        want_en <= 1'b1;
        wait_en(1'b1);
        temp_c <= `TEMP_LIMIT_C;
        tick(5);
        chk1(out_en, 1'b1);
        temp_c <= 8'h51;
        wait_en(1'b0);
        tick(2);
        chk1(drv_ok, 1'b0);
        rdchk(`OFS_ERR, 32'h1);
        temp_c <= 8'h19;
        tick(5);
        chk1(out_en, 1'b0);
        want_en <= 1'b0;
        tick(6);
        want_en <= 1'b1;
        wait_en(1'b1);
        chk1(drv_ok, 1'b1);
        rdchk(`OFS_ERR, 32'h0);
        fault_in <= 1'b1;
        tick(1);
        fault_in <= 1'b0;
        wait_en(1'b0);
        rdchk(`OFS_ERR, 32'h2);
        // software enable ignores the pin
        wr(`OFS_CTRL, 32'h80);
        wr(`OFS_CTRL, 32'h81);
        wait_en(1'b1);
        rdchk(`OFS_CTRL, 32'h81);
        want_en <= 1'b0;
        tick(6);
        chk1(out_en, 1'b1);
        // host link attaches
        host_link <= 1'b1;
        tick(2);
        chk1(panel_en, 1'b0);
        rdchk(`OFS_SETP, 32'hFF);
        // save, alter, load
        wr(`OFS_SETP, 32'h40);
        wr(`OFS_CMD, 32'h2);
        wr(`OFS_SETP, 32'h55);
        wr(`OFS_CMD, 32'h1);
        rdchk(`OFS_SETP, 32'h40);
        rdchk(`OFS_LIMIT, 32'h32);
        wait_en(1'b0);
        rdchk(`OFS_CTRL, 32'h80);
        // live set now differs from the saved one and asks for defaults
        wr(`OFS_CTRL, 32'h88);
        wr(`OFS_SETP, 32'h55);
        // power-up again with a failing self test
        rst <= 1'b1;
        st_ok <= 1'b0;
        tick(3);
        rst <= 1'b0;
        tick(2);
        rdchk(`OFS_SETP, 32'h40);
        rdchk(`OFS_CTRL, 32'h80);
        tick(60);
        chk1(drv_ok, 1'b0);
        rdchk(`OFS_ERR, 32'h4);
        bus(1'b0, `OFS_STAT, 32'h0);
        check({30'h0, rd[19:18]}, 32'h3);
        st_ok <= 1'b1;
        tick(5);
        chk1(drv_ok, 1'b0);
        tally_and_finish();
    end
endmodule : laser_driver_enable_setpoint_ctrl_test
